/* rtl/eoc_delay.sv */
// One delayed-activation countdown counting whole seconds
`timescale 1ns/1ps
module eoc_delay #(
  parameter int DLY_W = 8
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Second tick, argument level and programmed delay
  input  wire logic             tick_i,
  input  wire logic             arm_i,
  input  wire logic [DLY_W-1:0] delay_s_i,
  // Expiry level
  output logic                  expired_o
);

  localparam int REM_W = DLY_W + 1;
  localparam logic [REM_W-1:0] EXTRA = REM_W'(eoc_pkg::DELAY_EXTRA_S);

  if (DLY_W < 1 || DLY_W > 30) begin : g_chk_dly
    $error("DLY_W must be 1 to 30");
  end

  logic [REM_W-1:0] remain_q;
  logic             exp_q;
  logic [REM_W-1:0] full_w;

  assign full_w = REM_W'(delay_s_i) + EXTRA;

  always_ff @(posedge clk_i) begin
    if (rst_i || !arm_i) begin
      remain_q <= full_w;
      exp_q    <= 1'b0;
    end else if (tick_i && !exp_q) begin
      remain_q <= remain_q - REM_W'(1);
      exp_q    <= (remain_q == REM_W'(1));
    end
  end

  assign expired_o = exp_q;

  sequence last_tick_s;
    arm_i && tick_i && !exp_q && remain_q == REM_W'(1);
  endsequence

  reload_on_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !arm_i |=> !expired_o && remain_q == $past(full_w))
    else $error("delay not reloaded when argument dropped");

  expire_time_a: assert property (@(posedge clk_i) disable iff (rst_i)
    last_tick_s ##1 arm_i |-> expired_o)
    else $error("delay did not expire on its last tick");

  no_early_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(expired_o) |-> $past(remain_q) == REM_W'(1) && $past(tick_i))
    else $error("delay expired before counting down");

endmodule : eoc_delay

/* rtl/eoc_engine.sv */
// Equation-driven output control engine with flags, counters, delays and thresholds
`timescale 1ns/1ps
module eoc_engine #(
  parameter int NUM_EQ      = 16,
  parameter int NUM_TMR     = 4,
  parameter int CNT_W       = 8,
  parameter int TICK_CYCLES = eoc_pkg::TICK_CYCLES_DEF
) (
  // Clock and system reset
  input  wire logic                          CLOCK_I,
  input  wire logic                          RESET_I,
  // Program load
  input  wire logic                          LOAD_WE_I,
  input  wire logic [$clog2(NUM_EQ)-1:0]     LOAD_ADDR_I,
  input  wire logic [eoc_pkg::EQ_W-1:0]      LOAD_DATA_I,
  input  wire logic                          LOAD_DONE_I,
  // Initiating device pins
  input  wire logic [eoc_pkg::NUM_PT-1:0]    ALARM_I,
  input  wire logic [eoc_pkg::NUM_PT-1:0]    SUPV_I,
  input  wire logic [eoc_pkg::NUM_PT-1:0]    TRBL_I,
  input  wire logic [eoc_pkg::NUM_PT-1:0]    PREALM_I,
  // Cutout period window from the cycling timer, same clock
  input  wire logic                          CUTOUT_WINDOW_I,
  // Results
  output logic      [eoc_pkg::NUM_PT-1:0]    OUT_ACTIVE_O,
  output logic      [eoc_pkg::NUM_PT-1:0]    FLAG_O,
  output logic      [2*eoc_pkg::NUM_PT-1:0]  FLAG_TYPE_O,
  output logic      [CNT_W*eoc_pkg::NUM_PT-1:0] COUNTER_O,
  output logic      [eoc_pkg::NUM_PT-1:0]    ALARM_ADJ_O,
  output logic      [eoc_pkg::NUM_PT-1:0]    PREALM_ADJ_O,
  output logic                               PASS_DONE_O
);

  localparam int NP    = eoc_pkg::NUM_PT;
  localparam int PC_W  = $clog2(NUM_EQ);
  localparam int TCK_W = $clog2(TICK_CYCLES + 1);
  localparam logic [PC_W-1:0] PC_LAST = PC_W'(NUM_EQ - 1);

  if (NUM_EQ < 2 || NUM_EQ > 256 || (NUM_EQ & (NUM_EQ - 1)) != 0) begin : g_chk_eq
    $error("NUM_EQ must be a power of two from 2 to 256");
  end
  if (NUM_TMR < 1 || NUM_TMR > 4) begin : g_chk_tmr
    $error("NUM_TMR must be 1 to 4");
  end
  if (CNT_W < 5) begin : g_chk_cnt
    $error("CNT_W must hold a count of 16");
  end
  if (TICK_CYCLES < 2) begin : g_chk_tick
    $error("TICK_CYCLES must be at least 2");
  end

  function automatic logic [NP-1:0] rmask(input logic [3:0] lo, input logic [3:0] hi);
    logic [NP-1:0] m;
    m = '0;
    for (int i = 0; i < NP; i++) begin
      if (i >= int'(lo) && i <= int'(hi)) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : rmask

  function automatic logic [4:0] popcnt(input logic [NP-1:0] v);
    logic [4:0] c;
    c = '0;
    for (int i = 0; i < NP; i++) begin
      c = c + 5'(v[i]);
    end
    return c;
  endfunction : popcnt

  // Filtered pins
  logic [NP-1:0] alarm_s;
  logic [NP-1:0] supv_s;
  logic [NP-1:0] trbl_s;
  logic [NP-1:0] pre_s;

  eoc_sync #(.WIDTH(NP)) u_sync_alarm (.clk_i(CLOCK_I), .rst_i(RESET_I), .async_i(ALARM_I),
    .sync_o(alarm_s));
  eoc_sync #(.WIDTH(NP)) u_sync_supv (.clk_i(CLOCK_I), .rst_i(RESET_I), .async_i(SUPV_I),
    .sync_o(supv_s));
  eoc_sync #(.WIDTH(NP)) u_sync_trbl (.clk_i(CLOCK_I), .rst_i(RESET_I), .async_i(TRBL_I),
    .sync_o(trbl_s));
  eoc_sync #(.WIDTH(NP)) u_sync_pre (.clk_i(CLOCK_I), .rst_i(RESET_I), .async_i(PREALM_I),
    .sync_o(pre_s));

  // Program store and sequencer
  logic [eoc_pkg::EQ_W-1:0]  prog_q [NUM_EQ];
  logic                      prog_ok_q;
  logic [PC_W-1:0]           pc_q;
  eoc_pkg::eoc_state_type    state_q;
  logic                      pass_done_q;
  logic                      init_w;

  assign init_w = RESET_I || LOAD_DONE_I;

  always_ff @(posedge CLOCK_I) begin
    if (LOAD_WE_I) begin
      prog_q[LOAD_ADDR_I] <= LOAD_DATA_I;
    end
  end

  // Engine idles after reset until a program load completes
  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      prog_ok_q <= 1'b0;
    end else if (LOAD_DONE_I) begin
      prog_ok_q <= 1'b1;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (init_w) begin
      state_q     <= eoc_pkg::ST_RUN;
      pc_q        <= '0;
      pass_done_q <= 1'b0;
    end else begin
      pass_done_q <= 1'b0;
      case (state_q)
        eoc_pkg::ST_RUN: begin
          pc_q <= pc_q + PC_W'(1);
          if (pc_q == PC_LAST) begin
            state_q <= eoc_pkg::ST_COMMIT;
          end
        end
        eoc_pkg::ST_COMMIT: begin
          state_q     <= eoc_pkg::ST_RUN;
          pass_done_q <= 1'b1;
        end
        default: begin
          state_q <= eoc_pkg::ST_RUN;
        end
      endcase
    end
  end

  // Decode of the current equation
  logic [eoc_pkg::EQ_W-1:0]  eq;
  eoc_pkg::eoc_op_type       op;
  eoc_pkg::eoc_kind_type     kind;
  eoc_pkg::eoc_evt_type      fld_type;
  logic                      neg;
  logic                      cfg;
  logic [eoc_pkg::TMR_W-1:0] tmr;
  logic [3:0]                src_lo;
  logic [3:0]                src_hi;
  logic [3:0]                dst_lo;
  logic [NP-1:0]             dmask;
  logic [eoc_pkg::DLY_W-1:0] dly;
  logic                      exec;

  assign eq       = prog_q[pc_q];
  assign op       = eoc_pkg::eoc_op_type'(eq[eoc_pkg::OP_LSB +: eoc_pkg::OP_W]);
  assign kind     = eoc_pkg::eoc_kind_type'(eq[eoc_pkg::KIND_LSB +: 2]);
  assign fld_type = eoc_pkg::eoc_evt_type'(eq[eoc_pkg::TYPE_LSB +: 2]);
  assign neg      = eq[eoc_pkg::NEG_BIT];
  assign cfg      = eq[eoc_pkg::CFG_BIT];
  assign tmr      = eq[eoc_pkg::TMR_LSB +: eoc_pkg::TMR_W];
  assign src_lo   = eq[eoc_pkg::SRC_LO_LSB +: eoc_pkg::PT_W];
  assign src_hi   = eq[eoc_pkg::SRC_HI_LSB +: eoc_pkg::PT_W];
  assign dst_lo   = eq[eoc_pkg::DST_LO_LSB +: eoc_pkg::PT_W];
  assign dmask    = rmask(dst_lo, eq[eoc_pkg::DST_HI_LSB +: eoc_pkg::PT_W]);
  assign dly      = eq[eoc_pkg::DLY_LSB +: eoc_pkg::DLY_W];
  assign exec     = prog_ok_q && state_q == eoc_pkg::ST_RUN;

  // Virtual state
  logic [NP-1:0]             flags_q;
  eoc_pkg::eoc_evt_type      flag_type_q [NP];
  logic [CNT_W-1:0]          cnt_q [NP];
  eoc_pkg::eoc_evt_type      cnt_type_q [NP];
  logic [NUM_TMR-1:0]        tmr_exp;

  // Argument evaluation
  logic [NP-1:0]             src_vec;
  logic [CNT_W-1:0]          src_raw;
  logic [CNT_W-1:0]          src_val;
  eoc_pkg::eoc_evt_type      src_type;
  logic                      src_true;
  logic                      dly_fire;

  always_comb begin
    case (fld_type)
      eoc_pkg::EVT_ALARM: src_vec = alarm_s;
      eoc_pkg::EVT_SUPV:  src_vec = supv_s;
      eoc_pkg::EVT_TRBL:  src_vec = trbl_s;
      default:            src_vec = pre_s;
    endcase
    src_raw  = CNT_W'(popcnt(src_vec & rmask(src_lo, src_hi)));
    src_type = fld_type;
    if (kind == eoc_pkg::KIND_FLAG) begin
      src_raw  = CNT_W'(flags_q[src_lo]);
      src_type = flag_type_q[src_lo];
    end else if (kind == eoc_pkg::KIND_CNT) begin
      src_raw  = cnt_q[src_lo];
      src_type = cnt_type_q[src_lo];
    end
    src_true = (src_raw != '0) ^ neg;
    src_val  = neg ? CNT_W'(src_true) : src_raw;
    dly_fire = src_true && tmr_exp[tmr];
  end

  // Flags take 1 from a set and 0 from a negated set, so a later alarm sets a cleared flag again
  always_ff @(posedge CLOCK_I) begin
    if (init_w) begin
      flags_q <= {NP{eoc_pkg::FLAG_RESET}};
    end else if (exec && src_true && op == eoc_pkg::OP_FLAG) begin
      flags_q <= flags_q | dmask;
    end else if (exec && src_true && op == eoc_pkg::OP_NFLAG) begin
      flags_q <= flags_q & ~dmask;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    for (int i = 0; i < NP; i++) begin
      if (init_w) begin
        flag_type_q[i] <= eoc_pkg::EVT_ALARM;
      end else if (exec && src_true && op == eoc_pkg::OP_FLAG && dmask[i]) begin
        flag_type_q[i] <= src_type;
      end
    end
  end

  // A negated argument writes its truth as 0 or 1 to the counter; each write replaces the old value
  always_ff @(posedge CLOCK_I) begin
    for (int i = 0; i < NP; i++) begin
      if (RESET_I || LOAD_DONE_I) begin
        cnt_q[i]      <= '0;
        cnt_type_q[i] <= eoc_pkg::EVT_ALARM;
      end else if (exec && dmask[i] && op == eoc_pkg::OP_CNT) begin
        cnt_q[i]      <= src_val;
        cnt_type_q[i] <= src_type;
      end else if (exec && dmask[i] && op == eoc_pkg::OP_DLYC) begin
        cnt_q[i]      <= dly_fire ? src_val : '0;
        cnt_type_q[i] <= src_type;
      end
    end
  end

  // Physical outputs: latched, cutout-latched and per-pass tracked parts
  logic [NP-1:0] latch_q;
  logic [NP-1:0] cyc_q;
  logic [NP-1:0] track_q;
  logic [NP-1:0] out_q;
  logic [NP-1:0] drive_acc_q;
  logic [NP-1:0] kill_acc_q;
  logic          is_alarm;
  logic          commit;

  assign is_alarm = src_type == eoc_pkg::EVT_ALARM;
  assign commit   = state_q == eoc_pkg::ST_COMMIT;

  always_ff @(posedge CLOCK_I) begin
    if (init_w) begin
      latch_q <= '0;
      cyc_q   <= '0;
    end else if (exec && src_true) begin
      if (op == eoc_pkg::OP_OUT && is_alarm && cfg) begin
        cyc_q <= cyc_q | dmask;
      end else if (op == eoc_pkg::OP_OUT && is_alarm) begin
        latch_q <= latch_q | dmask;
      end else if (op == eoc_pkg::OP_DLY && is_alarm && tmr_exp[tmr]) begin
        latch_q <= latch_q | dmask;
      end else if (op == eoc_pkg::OP_NOUT) begin
        latch_q <= latch_q & ~dmask;
        cyc_q   <= cyc_q & ~dmask;
      end
    end
  end

  // Tracked drive is gathered over a pass so the outputs do not glitch mid-pass
  always_ff @(posedge CLOCK_I) begin
    if (init_w || commit) begin
      drive_acc_q <= '0;
      kill_acc_q  <= '0;
    end else if (exec && src_true && !is_alarm) begin
      if (op == eoc_pkg::OP_OUT || (op == eoc_pkg::OP_DLY && tmr_exp[tmr])) begin
        drive_acc_q <= drive_acc_q | dmask;
      end else if (op == eoc_pkg::OP_NOUT) begin
        kill_acc_q <= kill_acc_q | dmask;
      end
    end else if (exec && src_true && op == eoc_pkg::OP_NOUT) begin
      kill_acc_q <= kill_acc_q | dmask;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (init_w) begin
      track_q <= '0;
    end else if (commit) begin
      track_q <= drive_acc_q & ~kill_acc_q;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (init_w) begin
      out_q <= '0;
    end else begin
      out_q <= latch_q | track_q | (cyc_q & {NP{CUTOUT_WINDOW_I}});
    end
  end

  // Threshold adjustment
  logic [NP-1:0] athr_lat_q;
  logic [NP-1:0] athr_acc_q;
  logic [NP-1:0] athr_trk_q;
  logic [NP-1:0] pthr_acc_q;
  logic [NP-1:0] pthr_trk_q;

  always_ff @(posedge CLOCK_I) begin
    if (init_w) begin
      athr_lat_q <= '0;
    end else if (exec && src_true && op == eoc_pkg::OP_ATHR && is_alarm &&
                 (cfg || kind == eoc_pkg::KIND_FLAG)) begin
      athr_lat_q <= athr_lat_q | dmask;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (init_w || commit) begin
      athr_acc_q <= '0;
      pthr_acc_q <= '0;
    end else if (exec && src_true && op == eoc_pkg::OP_ATHR && is_alarm) begin
      athr_acc_q <= athr_acc_q | dmask;
    end else if (exec && src_true && op == eoc_pkg::OP_PTHR &&
                 src_type == eoc_pkg::EVT_PRE) begin
      pthr_acc_q <= pthr_acc_q | dmask;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (init_w) begin
      athr_trk_q <= '0;
      pthr_trk_q <= '0;
    end else if (commit) begin
      athr_trk_q <= athr_acc_q;
      pthr_trk_q <= pthr_acc_q;
    end
  end

  // One-second tick and delay timers
  logic [TCK_W-1:0]          tick_cnt_q;
  logic                      tick;
  logic [NUM_TMR-1:0]        arm_q;
  logic [NUM_TMR-1:0]        arm_acc_q;
  logic [eoc_pkg::DLY_W-1:0] tmr_load_q [NUM_TMR];
  logic                      is_dly;

  assign tick   = tick_cnt_q == TCK_W'(TICK_CYCLES - 1);
  assign is_dly = op == eoc_pkg::OP_DLY || op == eoc_pkg::OP_DLYC;

  always_ff @(posedge CLOCK_I) begin
    if (init_w || tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + TCK_W'(1);
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (init_w) begin
      arm_q     <= '0;
      arm_acc_q <= '0;
    end else if (commit) begin
      arm_q     <= arm_acc_q;
      arm_acc_q <= '0;
    end else if (exec && is_dly && src_true && int'(tmr) < NUM_TMR) begin
      arm_acc_q[tmr] <= 1'b1;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    for (int t = 0; t < NUM_TMR; t++) begin
      if (init_w) begin
        tmr_load_q[t] <= '0;
      end else if (exec && is_dly && int'(tmr) == t) begin
        tmr_load_q[t] <= dly;
      end
    end
  end

  for (genvar t = 0; t < NUM_TMR; t++) begin : g_tmr
    eoc_delay #(.DLY_W(eoc_pkg::DLY_W)) u_delay (
      .clk_i     (CLOCK_I),
      .rst_i     (init_w),
      .tick_i    (tick),
      .arm_i     (arm_q[t]),
      .delay_s_i (tmr_load_q[t]),
      .expired_o (tmr_exp[t])
    );
  end

  // Output packing
  for (genvar i = 0; i < NP; i++) begin : g_pack
    assign FLAG_TYPE_O[2*i +: 2]     = flag_type_q[i];
    assign COUNTER_O[CNT_W*i +: CNT_W] = cnt_q[i];
  end

  assign OUT_ACTIVE_O = out_q;
  assign FLAG_O       = flags_q;
  assign ALARM_ADJ_O  = athr_lat_q | athr_trk_q;
  assign PREALM_ADJ_O = pthr_trk_q;
  assign PASS_DONE_O  = pass_done_q;

  default clocking cb @(posedge CLOCK_I); endclocking

  flags_reset_a: assert property (RESET_I |=> FLAG_O == '0 && ALARM_ADJ_O == '0)
    else $error("flags or thresholds survived reset");

  flags_load_a: assert property (disable iff (RESET_I) LOAD_DONE_I |=> FLAG_O == '0)
    else $error("flags not cleared by program load");

  flag_set_a: assert property (disable iff (init_w)
    exec && src_true && op == eoc_pkg::OP_FLAG |=> (flags_q & $past(dmask)) == $past(dmask))
    else $error("flag not set by true equation");

  flag_hold_a: assert property (disable iff (init_w)
    !(exec && src_true && op == eoc_pkg::OP_NFLAG) |=>
      (flags_q & $past(flags_q)) == $past(flags_q))
    else $error("flag cleared without negation or reset");

  neg_out_a: assert property (disable iff (init_w)
    exec && src_true && op == eoc_pkg::OP_NOUT |=> (latch_q & $past(dmask)) == '0)
    else $error("negated output still latched");

  alarm_latch_a: assert property (disable iff (init_w)
    !(exec && src_true && op == eoc_pkg::OP_NOUT) |=>
      (latch_q & $past(latch_q)) == $past(latch_q))
    else $error("latched output dropped without negation");

  track_commit_a: assert property (disable iff (init_w)
    commit |=> track_q == $past(drive_acc_q & ~kill_acc_q) ##1 PASS_DONE_O == 1'b0)
    else $error("tracked outputs not committed at pass end");

  cutout_gate_a: assert property (disable iff (init_w)
    !CUTOUT_WINDOW_I |=> (OUT_ACTIVE_O & ~$past(latch_q | track_q)) == '0)
    else $error("cyclical output driven outside cutout window");

  cnt_reset_a: assert property (RESET_I |=> COUNTER_O == '0)
    else $error("counters not cleared by reset");

  cnt_last_a: assert property (disable iff (init_w)
    exec && op == eoc_pkg::OP_CNT && dmask[dst_lo] |=> cnt_q[$past(dst_lo)] == $past(src_val))
    else $error("counter does not hold last written value");

  pass_order_a: assert property (disable iff (init_w)
    state_q == eoc_pkg::ST_RUN && pc_q != PC_LAST |=> pc_q == $past(pc_q) + PC_W'(1))
    else $error("equations not executed in order");

endmodule : eoc_engine

/* rtl/eoc_pkg.sv */
// Constants, field layout and types shared by the event output control engine
package eoc_pkg;

  // Timing
  localparam int CLK_MHZ         = 40;
  localparam int TICK_PERIOD_MS  = 1000;
  localparam int TICK_CYCLES_DEF = TICK_PERIOD_MS * 1000 * CLK_MHZ;
  localparam int DELAY_EXTRA_S   = 3;

  // Point addressing
  localparam int PT_W   = 4;
  localparam int NUM_PT = 16;

  // Equation word layout
  localparam int EQ_W       = 40;
  localparam int DLY_LSB    = 32;
  localparam int DLY_W      = 8;
  localparam int OP_LSB     = 28;
  localparam int OP_W       = 4;
  localparam int KIND_LSB   = 26;
  localparam int TYPE_LSB   = 24;
  localparam int NEG_BIT    = 23;
  localparam int CFG_BIT    = 22;
  localparam int TMR_LSB    = 20;
  localparam int TMR_W      = 2;
  localparam int SRC_LO_LSB = 16;
  localparam int SRC_HI_LSB = 12;
  localparam int DST_LO_LSB = 8;
  localparam int DST_HI_LSB = 4;

  // Values after reset
  localparam logic FLAG_RESET = 1'b0;

  typedef enum logic [3:0] {
    OP_NOP   = 4'h0,
    OP_CNT   = 4'h1,
    OP_FLAG  = 4'h2,
    OP_NFLAG = 4'h3,
    OP_OUT   = 4'h4,
    OP_NOUT  = 4'h5,
    OP_ATHR  = 4'h6,
    OP_PTHR  = 4'h7,
    OP_DLY   = 4'h8,
    OP_DLYC  = 4'h9
  } eoc_op_type;

  typedef enum logic [1:0] {
    KIND_INPUT = 2'h0,
    KIND_FLAG  = 2'h1,
    KIND_CNT   = 2'h2
  } eoc_kind_type;

  typedef enum logic [1:0] {
    EVT_ALARM = 2'h0,
    EVT_SUPV  = 2'h1,
    EVT_TRBL  = 2'h2,
    EVT_PRE   = 2'h3
  } eoc_evt_type;

  typedef enum logic [1:0] {
    ST_RUN    = 2'b01,
    ST_COMMIT = 2'b10
  } eoc_state_type;

endpackage : eoc_pkg

/* rtl/eoc_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module eoc_sync #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Pins and filtered levels
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] lvl_q;

  if (WIDTH < 1) begin : g_chk_width
    $error("WIDTH must be at least 1");
  end

  always_ff @(posedge clk_i) begin
    s1_q <= async_i;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  // A bit moves only when the last two stages agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lvl_q <= '0;
    end else begin
      lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
    end
  end

  assign sync_o = lvl_q;

endmodule : eoc_sync

/* testbench/eoc_devices.sv */
// Initiating device pins and cutout window of the far side
`timescale 1ns/1ps
module eoc_devices (
  // Clock and commanded device levels
  input  wire logic        clk_i,
  input  wire logic [63:0] lvl_i,
  // Pins and cutout window
  output logic      [63:0] pins_o,
  output logic             window_o
);
  logic [3:0] win_q = 4'h0;
  // Devices change state only on a clock edge; window is high half of every 16 cycles
  always @(posedge clk_i) begin
    pins_o   <= lvl_i;
    win_q    <= win_q + 4'h1;
    window_o <= win_q[3];
  end
endmodule : eoc_devices

/* testbench/tb_top.sv */
// Self-checking bench for the event output control engine
`timescale 1ns/1ps
module tb_top;
  logic         clk  = 1'b0;
  logic         rst  = 1'b1;
  logic         we   = 1'b0;
  logic         done = 1'b0;
  logic [3:0]   addr = 4'h0;
  logic [39:0]  data = 40'h0;
  logic [63:0]  lvl  = 64'h0;
  logic [63:0]  pins;
  logic         win, pdone;
  logic [15:0]  outs, flags, aadj, padj;
  logic [31:0]  ftype;
  logic [127:0] cnt;
  logic [31:0]  lfsr = 32'h000129d7;
  logic [39:0]  prog [16];
  logic [3:0]   v;
  logic         any  = 1'b0;
  logic         w;
  int           n;
  int miscompares = 0, cmp_count = 0, cycles = 0;

  initial forever #12.5 clk = ~clk;

  eoc_engine #(.NUM_EQ(16), .TICK_CYCLES(20)) u_dut (
    .CLOCK_I(clk), .RESET_I(rst), .LOAD_WE_I(we), .LOAD_ADDR_I(addr),
    .LOAD_DATA_I(data), .LOAD_DONE_I(done), .ALARM_I(pins[15:0]),
    .SUPV_I(pins[31:16]), .TRBL_I(pins[47:32]), .PREALM_I(pins[63:48]),
    .CUTOUT_WINDOW_I(win), .OUT_ACTIVE_O(outs), .FLAG_O(flags),
    .FLAG_TYPE_O(ftype), .COUNTER_O(cnt), .ALARM_ADJ_O(aadj),
    .PREALM_ADJ_O(padj), .PASS_DONE_O(pdone));

  eoc_devices u_dev (.clk_i(clk), .lvl_i(lvl), .pins_o(pins), .window_o(win));

  function automatic logic [39:0] eq(logic [3:0] op, logic [1:0] kind, typ,
                                     logic neg, logic [3:0] slo, shi, dlo, dhi);
    return {8'h01, op, kind, typ, neg, 3'h0, slo, shi, dlo, dhi, 4'h0};
  endfunction : eq

  function automatic logic [15:0] cnt4(logic [3:0] x);
    return 16'(x[0]) + 16'(x[1]) + 16'(x[2]) + 16'(x[3]);
  endfunction : cnt4

  function automatic logic [31:0] lfsr_next(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic check(string name, logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end

  initial begin
    foreach (prog[i]) prog[i] = 40'h0;
    prog[0] = eq(4'h2, 2'h0, 2'h0, 1'b0, 4'h0, 4'h3, 4'h2, 4'h2);
    prog[1] = eq(4'h1, 2'h0, 2'h0, 1'b0, 4'h0, 4'h3, 4'h0, 4'h0);
    prog[2] = eq(4'h4, 2'h1, 2'h0, 1'b0, 4'h2, 4'h2, 4'h0, 4'h1);
    prog[3] = eq(4'h4, 2'h0, 2'h1, 1'b0, 4'h4, 4'h4, 4'h5, 4'h5);
    prog[4] = eq(4'h8, 2'h1, 2'h0, 1'b0, 4'h2, 4'h2, 4'h8, 4'h8);
    prog[5] = eq(4'h3, 2'h0, 2'h2, 1'b0, 4'h6, 4'h6, 4'h2, 4'h2);
    prog[6] = eq(4'h5, 2'h0, 2'h2, 1'b0, 4'h6, 4'h6, 4'h0, 4'h1);
    prog[7] = eq(4'h1, 2'h0, 2'h3, 1'b1, 4'h7, 4'h7, 4'h1, 4'h1);
    prog[8] = eq(4'h6, 2'h0, 2'h0, 1'b0, 4'h0, 4'h3, 4'hc, 4'hd);
    prog[9] = eq(4'h7, 2'h0, 2'h3, 1'b0, 4'h7, 4'h7, 4'he, 4'he);
    // Cyclical alarm output, and a delayed counter on the second timer
    prog[10] = eq(4'h4, 2'h0, 2'h0, 1'b0, 4'h0, 4'h3, 4'ha, 4'ha) | 40'h0000400000;
    prog[11] = eq(4'h9, 2'h1, 2'h0, 1'b0, 4'h2, 4'h2, 4'h3, 4'h3) | 40'h0000100000;
    cyc(20);
    rst <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      we <= 1'b1; addr <= 4'(i); data <= prog[i];
    end
    @(posedge clk) begin we <= 1'b0; done <= 1'b1; end
    @(posedge clk) done <= 1'b0;
    cyc(40);
    check("flags", flags, 16'h0000);
    check("cnt0", 16'(cnt[7:0]), 16'h0000);
    check("padj", 16'(padj[14]), 16'h0000);
    check("cnt1", 16'(cnt[15:8]), 16'h0001);
    // First value lights every source of the range, the rest are random
    for (int i = 0; i < 6; i++) begin
      lfsr = lfsr_next(lfsr);
      v = (i == 0) ? 4'hf : lfsr[3:0];
      any |= (v != 4'h0);
      @(posedge clk) lvl[3:0] <= v;
      cyc(40);
      check("cnt0", 16'(cnt[7:0]), cnt4(v));
      check("flag2", 16'(flags[2]), 16'(any));
      check("aadj", 16'(aadj[13:12]), (v != 4'h0) ? 16'h0003 : 16'h0000);
      if (i == 0) check("out8", 16'(outs[8]), 16'h0000);
    end
    check("out8", 16'(outs[8]), 16'h0001);
    check("ftype", 16'(ftype[5:4]), 16'h0000);
    check("cnt3", 16'(cnt[31:24]), 16'h0001);
    // Cyclical output follows the window one register late; four passes span 68 cycles
    n = 0;
    repeat (68) begin
      w = win;
      @(posedge clk);
      n += int'(pdone);
      check("out10", 16'(outs[10]), 16'(w));
    end
    check("passes", 16'(n), 16'h0004);
    @(posedge clk) begin lvl[3:0] <= 4'h0; lvl[20] <= 1'b1; lvl[55] <= 1'b1; end
    cyc(40);
    check("flag2", 16'(flags[2]), 16'h0001);
    check("out01", 16'(outs[1:0]), 16'h0003);
    check("out5", 16'(outs[5]), 16'h0001);
    check("cnt1", 16'(cnt[15:8]), 16'h0000);
    check("aadj", 16'(aadj[13:12]), 16'h0000);
    check("padj", 16'(padj[14]), 16'h0001);
    @(posedge clk) begin lvl[20] <= 1'b0; lvl[38] <= 1'b1; lvl[55] <= 1'b0; end
    cyc(40);
    check("out5", 16'(outs[5]), 16'h0000);
    check("padj", 16'(padj[14]), 16'h0000);
    check("cnt3", 16'(cnt[31:24]), 16'h0000);
    check("flag2", 16'(flags[2]), 16'h0000);
    check("out01", 16'(outs[1:0]), 16'h0000);
    @(posedge clk) begin lvl[38] <= 1'b0; lvl[0] <= 1'b1; end
    cyc(40);
    rst <= 1'b1;
    cyc(4);
    check("flags", flags, 16'h0000);
    check("cnt", 16'(cnt[15:0]), 16'h0000);
    rst <= 1'b0;
    @(posedge clk) done <= 1'b1;
    @(posedge clk) done <= 1'b0;
    cyc(40);
    check("flag2", 16'(flags[2]), 16'h0001);
    final_report();
  end
endmodule : tb_top
